// ==== bmw_pkg.sv ====
// Constants for the bridge memory window register bank.
// Assumes a 25 MHz core clock and a plain strobe register port.
//
// Behaviour
// - Memory window top field is writable bits 31:20; low 20 bits taken as ones.
// - Memory requests inside the memory window are forwarded across the bridge.
// - Memory window bottom field is writable bits 15:4; low 20 bits taken as zero.
// - Prefetch bottom bits 3:0 and top bits 19:16 are read-only, value one.
// - Prefetch bottom field bits 15:4 is writable address 31:20, resets to zero.
// - Prefetch top field bits 31:20 is writable address 31:20, resets to zero.
// - Separate writable word holds prefetch bottom address bits 63:32, resets zero.
// - 64-bit prefetch bottom joins upper word and low field; reads and writes forwarded.
// - 64-bit prefetch top joins its upper word and top field likewise.
// - Writable word holds prefetch top address bits 63:32, resets to zero.

package bmw_pkg;

	// ----------------------------------------
	// Bus shape
	// ----------------------------------------
	localparam int unsigned REG_ADDR_W = 8;
	localparam int unsigned REG_DATA_W = 32;
	localparam int unsigned MEM_ADDR_W = 64;

	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [7:0] OFF_MEM_WIN     = 8'h20;
	localparam logic [7:0] OFF_PREF_LOW    = 8'h24;
	localparam logic [7:0] OFF_PREF_BOT_HI = 8'h28;
	localparam logic [7:0] OFF_PREF_TOP_HI = 8'h2C;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int unsigned FIELD_W     = 12;
	localparam int unsigned CAP_W       = 4;
	localparam int unsigned LOW_W       = 20;
	localparam int unsigned BOT_LSB     = 4;
	localparam int unsigned BOT_MSB     = 15;
	localparam int unsigned TOP_LSB     = 20;
	localparam int unsigned TOP_MSB     = 31;
	localparam int unsigned BOT_CAP_LSB = 0;
	localparam int unsigned TOP_CAP_LSB = 16;

	// ----------------------------------------
	// Reset and fixed values
	// ----------------------------------------
	localparam logic [11:0] FIELD_RST = 12'h000;
	localparam logic [31:0] UPPER_RST = 32'h0000_0000;
	localparam logic [3:0]  CAP_64    = 4'h1;
	localparam logic [3:0]  RSVD_4    = 4'h0;
	localparam logic [19:0] LOW_ZERO  = 20'h0_0000;
	localparam logic [19:0] LOW_ONES  = 20'hF_FFFF;
	localparam logic [31:0] HIGH_ZERO = 32'h0000_0000;
	localparam logic [31:0] READ_IDLE = 32'h0000_0000;

endpackage

// ==== bmw_win_if.sv ====
// Interface joining the register bank to one window comparator.
// Assumes the bank drives bounds and address, the comparator answers.
`timescale 1ns/1ps
`default_nettype none

interface bmw_win_if;

	logic [63:0] bottom;
	logic [63:0] top;
	logic [63:0] addr;
	logic        hit;

	modport cmp (
		input  bottom,
		input  top,
		input  addr,
		output hit
	);

	modport user (
		output bottom,
		output top,
		output addr,
		input  hit
	);

endinterface

`default_nettype wire

// ==== bmw_win_cmp.sv ====
// Inclusive address window comparator.
// Assumes bounds are stable register values; purely combinational.
`timescale 1ns/1ps
`default_nettype none

module bmw_win_cmp (
	bmw_win_if.cmp win
);

	// ----------------------------------------
	// Range check
	// ----------------------------------------
	wire logic open_w;
	wire logic above_w;
	wire logic below_w;

	// Bottom above top leaves the window closed
	assign open_w  = win.bottom <= win.top;
	assign above_w = win.addr >= win.bottom;
	assign below_w = win.addr <= win.top;
	assign win.hit = open_w & above_w & below_w;

endmodule

`default_nettype wire

// ==== bmw_regs.sv ====
// Bridge memory window registers with forwarding decision.
// Assumes register port and requests on the same core clock.
`timescale 1ns/1ps
`default_nettype none

module bmw_regs (
	input  wire logic                             clock,
	input  wire logic                             resetn,
	input  wire logic [bmw_pkg::REG_ADDR_W-1:0]   reg_addr,
	input  wire logic [bmw_pkg::REG_DATA_W-1:0]   reg_wdata,
	input  wire logic                             reg_wr,
	input  wire logic                             reg_rd,
	output var  logic [bmw_pkg::REG_DATA_W-1:0]   reg_rdata,
	input  wire logic                             req_valid,
	input  wire logic                             req_is_mem,
	input  wire logic [bmw_pkg::MEM_ADDR_W-1:0]   req_addr,
	output var  logic                             fwd_valid,
	output var  logic                             fwd_mem,
	output var  logic                             fwd_pref,
	output var  logic [bmw_pkg::MEM_ADDR_W-1:0]   fwd_addr,
	output var  logic [bmw_pkg::MEM_ADDR_W-1:0]   mem_bottom,
	output var  logic [bmw_pkg::MEM_ADDR_W-1:0]   mem_top,
	output var  logic [bmw_pkg::MEM_ADDR_W-1:0]   pref_bottom,
	output var  logic [bmw_pkg::MEM_ADDR_W-1:0]   pref_top
);

	import bmw_pkg::*;

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	logic [FIELD_W-1:0] mem_bot_reg;
	logic [FIELD_W-1:0] mem_top_reg;
	logic [FIELD_W-1:0] pref_bot_reg;
	logic [FIELD_W-1:0] pref_top_reg;
	logic [31:0]        pref_bot_hi_reg;
	logic [31:0]        pref_top_hi_reg;
	logic [31:0]        rdata_reg;
	logic [31:0]        rdata_next;

	// ----------------------------------------
	// Forwarding pipeline state
	// ----------------------------------------
	logic               fwd_valid_reg;
	logic               fwd_mem_reg;
	logic               fwd_pref_reg;
	logic [63:0]        fwd_addr_reg;
	logic               fwd_mem_next;
	logic               fwd_pref_next;

	// ----------------------------------------
	// Expanded window bounds
	// ----------------------------------------
	logic [63:0]        mem_bottom_reg;
	logic [63:0]        mem_top_reg64;
	logic [63:0]        pref_bottom_reg;
	logic [63:0]        pref_top_reg64;
	wire logic [63:0]   mem_bottom_next;
	wire logic [63:0]   mem_top_next;
	wire logic [63:0]   pref_bottom_next;
	wire logic [63:0]   pref_top_next;

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	wire logic sel_mem_win;
	wire logic sel_pref_low;
	wire logic sel_bot_hi;
	wire logic sel_top_hi;
	wire logic sel_any;
	wire logic wr_mem_win;
	wire logic wr_pref_low;
	wire logic wr_bot_hi;
	wire logic wr_top_hi;

	assign sel_mem_win  = reg_addr == OFF_MEM_WIN;
	assign sel_pref_low = reg_addr == OFF_PREF_LOW;
	assign sel_bot_hi   = reg_addr == OFF_PREF_BOT_HI;
	assign sel_top_hi   = reg_addr == OFF_PREF_TOP_HI;
	assign sel_any      = sel_mem_win | sel_pref_low | sel_bot_hi | sel_top_hi;

	assign wr_mem_win   = reg_wr & sel_mem_win;
	assign wr_pref_low  = reg_wr & sel_pref_low;
	assign wr_bot_hi    = reg_wr & sel_bot_hi;
	assign wr_top_hi    = reg_wr & sel_top_hi;

	// ----------------------------------------
	// Write data fields
	// ----------------------------------------
	wire logic [FIELD_W-1:0] wd_bot_field;
	wire logic [FIELD_W-1:0] wd_top_field;

	assign wd_bot_field = reg_wdata[BOT_MSB:BOT_LSB];
	assign wd_top_field = reg_wdata[TOP_MSB:TOP_LSB];

	// ----------------------------------------
	// Memory window bottom
	// ----------------------------------------
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			mem_bot_reg <= FIELD_RST;
		end else if (wr_mem_win) begin
			mem_bot_reg <= wd_bot_field;
		end
	end

	// ----------------------------------------
	// Memory window top
	// ----------------------------------------
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			mem_top_reg <= FIELD_RST;
		end else if (wr_mem_win) begin
			mem_top_reg <= wd_top_field;
		end
	end

	// ----------------------------------------
	// Prefetch window bottom, low field
	// ----------------------------------------
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pref_bot_reg <= FIELD_RST;
		end else if (wr_pref_low) begin
			pref_bot_reg <= wd_bot_field;
		end
	end

	// ----------------------------------------
	// Prefetch window top, low field
	// ----------------------------------------
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pref_top_reg <= FIELD_RST;
		end else if (wr_pref_low) begin
			pref_top_reg <= wd_top_field;
		end
	end

	// ----------------------------------------
	// Prefetch window bottom, upper word
	// ----------------------------------------
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pref_bot_hi_reg <= UPPER_RST;
		end else if (wr_bot_hi) begin
			pref_bot_hi_reg <= reg_wdata;
		end
	end

	// ----------------------------------------
	// Prefetch window top, upper word
	// ----------------------------------------
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pref_top_hi_reg <= UPPER_RST;
		end else if (wr_top_hi) begin
			pref_top_hi_reg <= reg_wdata;
		end
	end

	// ----------------------------------------
	// Read words
	// ----------------------------------------
	wire logic [31:0] rd_mem_win;
	wire logic [31:0] rd_pref_low;

	// Reserved nibbles read zero, writes to them dropped
	assign rd_mem_win  = {mem_top_reg, RSVD_4, mem_bot_reg, RSVD_4};
	// Capability nibbles are constants, never stored
	assign rd_pref_low = {pref_top_reg, CAP_64, pref_bot_reg, CAP_64};

	// ----------------------------------------
	// Read data, valid the cycle after the strobe
	// ----------------------------------------
	always_comb begin
		rdata_next = READ_IDLE;
		if (reg_rd && sel_any) begin
			case (1'b1)
				sel_mem_win:  rdata_next = rd_mem_win;
				sel_pref_low: rdata_next = rd_pref_low;
				sel_bot_hi:   rdata_next = pref_bot_hi_reg;
				sel_top_hi:   rdata_next = pref_top_hi_reg;
				default:      rdata_next = READ_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rdata_reg <= READ_IDLE;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	assign reg_rdata = rdata_reg;

	// ----------------------------------------
	// Window bounds in full width
	// ----------------------------------------
	assign mem_bottom_next  = {HIGH_ZERO, mem_bot_reg, LOW_ZERO};
	assign mem_top_next     = {HIGH_ZERO, mem_top_reg, LOW_ONES};
	assign pref_bottom_next = {pref_bot_hi_reg, pref_bot_reg, LOW_ZERO};
	assign pref_top_next    = {pref_top_hi_reg, pref_top_reg, LOW_ONES};

	// Bound outputs lag the fields by one cycle
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			mem_bottom_reg <= {HIGH_ZERO, FIELD_RST, LOW_ZERO};
		end else begin
			mem_bottom_reg <= mem_bottom_next;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			mem_top_reg64 <= {HIGH_ZERO, FIELD_RST, LOW_ONES};
		end else begin
			mem_top_reg64 <= mem_top_next;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pref_bottom_reg <= {UPPER_RST, FIELD_RST, LOW_ZERO};
		end else begin
			pref_bottom_reg <= pref_bottom_next;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pref_top_reg64 <= {UPPER_RST, FIELD_RST, LOW_ONES};
		end else begin
			pref_top_reg64 <= pref_top_next;
		end
	end

	assign mem_bottom  = mem_bottom_reg;
	assign mem_top     = mem_top_reg64;
	assign pref_bottom = pref_bottom_reg;
	assign pref_top    = pref_top_reg64;

	// ----------------------------------------
	// Window comparators
	// ----------------------------------------
	bmw_win_if win_mem ();
	bmw_win_if win_pref ();

	// Compare against live fields so a write steers the next request
	assign win_mem.bottom  = mem_bottom_next;
	assign win_mem.top     = mem_top_next;
	assign win_mem.addr    = req_addr;
	assign win_pref.bottom = pref_bottom_next;
	assign win_pref.top    = pref_top_next;
	assign win_pref.addr   = req_addr;

	bmw_win_cmp u_cmp_mem (
		.win (win_mem.cmp)
	);

	bmw_win_cmp u_cmp_pref (
		.win (win_pref.cmp)
	);

	// ----------------------------------------
	// Forwarding decision
	// ----------------------------------------
	// Reads and writes alike; only memory requests qualify
	assign fwd_mem_next  = req_valid & req_is_mem & win_mem.hit;
	assign fwd_pref_next = req_valid & req_is_mem & win_pref.hit;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			fwd_valid_reg <= 1'b0;
		end else begin
			fwd_valid_reg <= req_valid;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			fwd_mem_reg  <= 1'b0;
			fwd_pref_reg <= 1'b0;
		end else begin
			fwd_mem_reg  <= fwd_mem_next;
			fwd_pref_reg <= fwd_pref_next;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			fwd_addr_reg <= {HIGH_ZERO, HIGH_ZERO};
		end else if (req_valid) begin
			fwd_addr_reg <= req_addr;
		end
	end

	assign fwd_valid = fwd_valid_reg;
	assign fwd_mem   = fwd_mem_reg;
	assign fwd_pref  = fwd_pref_reg;
	assign fwd_addr  = fwd_addr_reg;

endmodule

`default_nettype wire

// ==== bmw_regs_checker.sv ====
// Assertion checker for the bridge memory window register bank.
// Assumes it is bound to bmw_regs and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none

module bmw_regs_checker (
	input wire logic                           clock,
	input wire logic                           resetn,
	input wire logic [bmw_pkg::REG_ADDR_W-1:0] reg_addr,
	input wire logic [bmw_pkg::REG_DATA_W-1:0] reg_wdata,
	input wire logic                           reg_wr,
	input wire logic                           reg_rd,
	input wire logic [bmw_pkg::REG_DATA_W-1:0] reg_rdata,
	input wire logic                           req_valid,
	input wire logic                           req_is_mem,
	input wire logic [bmw_pkg::MEM_ADDR_W-1:0] req_addr,
	input wire logic                           fwd_valid,
	input wire logic                           fwd_mem,
	input wire logic                           fwd_pref,
	input wire logic [bmw_pkg::MEM_ADDR_W-1:0] fwd_addr,
	input wire logic [bmw_pkg::MEM_ADDR_W-1:0] mem_bottom,
	input wire logic [bmw_pkg::MEM_ADDR_W-1:0] mem_top,
	input wire logic [bmw_pkg::MEM_ADDR_W-1:0] pref_bottom,
	input wire logic [bmw_pkg::MEM_ADDR_W-1:0] pref_top
);
	import bmw_pkg::*;

	wire logic mapped_w;
	wire logic mem_hit_w;
	wire logic pref_hit_w;

	assign mapped_w   = (reg_addr == OFF_MEM_WIN) || (reg_addr == OFF_PREF_LOW)
		|| (reg_addr == OFF_PREF_BOT_HI) || (reg_addr == OFF_PREF_TOP_HI);
	assign mem_hit_w  = req_is_mem && (req_addr[63:32] == HIGH_ZERO) && (req_addr >= mem_bottom)
		&& (req_addr <= mem_top);
	assign pref_hit_w = req_is_mem && (req_addr >= pref_bottom) && (req_addr <= pref_top);

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!resetn);

	// ----------------------------------------
	// Sequences
	// ----------------------------------------
	sequence s_rd(logic [7:0] a);
		reg_rd && (reg_addr == a);
	endsequence
	sequence s_quiet_req;
		!reg_wr ##1 req_valid;
	endsequence
	sequence s_wr_bot_hi;
		(reg_wr && reg_addr == OFF_PREF_BOT_HI) ##1 !(reg_wr && reg_addr == OFF_PREF_BOT_HI);
	endsequence

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	AST_RD_MEM_WIN: assert property (s_rd(OFF_MEM_WIN) |=>
		reg_rdata == {mem_top[31:20], RSVD_4, mem_bottom[31:20], RSVD_4})
		else $error("memory window word read wrong");
	AST_RD_PREF_LOW: assert property (s_rd(OFF_PREF_LOW) |=>
		reg_rdata == {pref_top[31:20], CAP_64, pref_bottom[31:20], CAP_64})
		else $error("prefetch low word read wrong");
	AST_RD_BOT_HI: assert property (s_rd(OFF_PREF_BOT_HI) |=> reg_rdata == pref_bottom[63:32])
		else $error("prefetch bottom upper word read wrong");
	AST_RD_TOP_HI: assert property (s_rd(OFF_PREF_TOP_HI) |=> reg_rdata == pref_top[63:32])
		else $error("prefetch top upper word read wrong");
	AST_RD_IDLE: assert property (!(reg_rd && mapped_w) |=> reg_rdata == READ_IDLE)
		else $error("read data not idle");
	AST_BOUND_FORM: assert property (mem_bottom[19:0] == LOW_ZERO && mem_top[19:0] == LOW_ONES
		&& mem_top[63:32] == HIGH_ZERO && pref_bottom[19:0] == LOW_ZERO && pref_top[19:0] == LOW_ONES)
		else $error("window bound low bits wrong");
	AST_FWD_HIT: assert property (s_quiet_req |=> fwd_valid && fwd_mem == $past(mem_hit_w)
		&& fwd_pref == $past(pref_hit_w) && fwd_addr == $past(req_addr))
		else $error("forward decision wrong");
	AST_FWD_IDLE: assert property (!req_valid |=> !fwd_valid && !fwd_mem && !fwd_pref)
		else $error("forward without request");
	AST_WR_BOT_HI: assert property (s_wr_bot_hi |=> pref_bottom[63:32] == $past(reg_wdata, 2))
		else $error("prefetch bottom upper word not written");

endmodule

bind bmw_regs bmw_regs_checker u_chk (.clock(clock), .resetn(resetn), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.req_valid(req_valid), .req_is_mem(req_is_mem), .req_addr(req_addr), .fwd_valid(fwd_valid),
	.fwd_mem(fwd_mem), .fwd_pref(fwd_pref), .fwd_addr(fwd_addr), .mem_bottom(mem_bottom),
	.mem_top(mem_top), .pref_bottom(pref_bottom), .pref_top(pref_top));

`default_nettype wire

// ==== bmw_regs_tb.sv ====
// Self-checking bench for the bridge memory window register bank.
// Assumes bmw_regs as the design top and a 25 MHz core clock.
`timescale 1ns/1ps
`default_nettype none

module bmw_regs_tb;
	import bmw_pkg::*;

	logic        clock      = 1'b0;
	logic        resetn     = 1'b0;
	logic [7:0]  reg_addr   = 8'h00;
	logic [31:0] reg_wdata  = 32'h0000_0000;
	logic        reg_wr     = 1'b0;
	logic        reg_rd     = 1'b0;
	logic        req_valid  = 1'b0;
	logic        req_is_mem = 1'b0;
	logic [63:0] req_addr   = 64'h0000_0000_0000_0000;
	logic [31:0] reg_rdata;
	logic        fwd_valid, fwd_mem, fwd_pref;
	logic [63:0] fwd_addr, mem_bottom, mem_top, pref_bottom, pref_top;
	int          mismatches = 0;
	int          cmp_count  = 0;
	// Request table: address and {is_mem, expect mem hit, expect prefetch hit}
	logic [63:0] ra [10] = '{64'h0000_0000_0800_0000, 64'h0000_0000_07FF_FFFF, 64'h0000_0000_100F_FFFF,
		64'h0000_0000_1010_0000, 64'h0000_0001_1800_0000, 64'h0000_0001_200F_FFFF,
		64'h0000_0001_17FF_FFFF, 64'h0000_0001_2010_0000, 64'h0000_0000_1800_0000, 64'h0000_0000_0900_0000};
	logic [2:0]  rf [10] = '{3'b110, 3'b100, 3'b110, 3'b100, 3'b101, 3'b101, 3'b100, 3'b100, 3'b100, 3'b000};

	always #20 clock = ~clock;

	bmw_regs uut (.clock(clock), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req_valid(req_valid),
		.req_is_mem(req_is_mem), .req_addr(req_addr), .fwd_valid(fwd_valid), .fwd_mem(fwd_mem),
		.fwd_pref(fwd_pref), .fwd_addr(fwd_addr), .mem_bottom(mem_bottom), .mem_top(mem_top),
		.pref_bottom(pref_bottom), .pref_top(pref_top));

	// ----------------------------------------
	// Access tasks
	// ----------------------------------------
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr    <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clock);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd   <= 1'b0;
		#1 chk(64'(reg_rdata), 64'(exp));
	endtask

	task automatic req(input logic [63:0] a, input logic [2:0] f);
		@(posedge clock);
		req_valid  <= 1'b1;
		req_is_mem <= f[2];
		req_addr   <= a;
		@(posedge clock);
		req_valid  <= 1'b0;
		#1 chk({61'h0, fwd_valid, fwd_mem, fwd_pref}, {61'h0, 1'b1, f[1:0]});
		chk(fwd_addr, a);
	endtask

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		repeat (4) @(posedge clock);
		resetn <= 1'b1;
		rd(8'h20, 32'h0000_0000);
		rd(8'h24, 32'h0001_0001);
		rd(8'h28, 32'h0000_0000);
		rd(8'h2C, 32'h0000_0000);
		chk(mem_top, 64'h0000_0000_000F_FFFF);
		req(64'h0000_0000_000F_FFFF, 3'b111);
		wr(8'h20, 32'hFFFF_FFFF);
		rd(8'h20, 32'hFFF0_FFF0);
		wr(8'h24, 32'hFFFF_FFFF);
		rd(8'h24, 32'hFFF1_FFF1);
		wr(8'h30, 32'h0000_0000);
		rd(8'h30, 32'h0000_0000);
		rd(8'h20, 32'hFFF0_FFF0);
		wr(8'h20, 32'h1000_0800);
		wr(8'h24, 32'h2000_1800);
		wr(8'h28, 32'h0000_0001);
		wr(8'h2C, 32'h0000_0001);
		rd(8'h20, 32'h1000_0800);
		rd(8'h24, 32'h2001_1801);
		rd(8'h28, 32'h0000_0001);
		rd(8'h2C, 32'h0000_0001);
		chk(mem_bottom, 64'h0000_0000_0800_0000);
		chk(mem_top, 64'h0000_0000_100F_FFFF);
		chk(pref_bottom, 64'h0000_0001_1800_0000);
		chk(pref_top, 64'h0000_0001_200F_FFFF);
		for (int i = 0; i < 10; i++) begin
			req(ra[i], rf[i]);
		end
		@(posedge clock);
		resetn <= 1'b0;
		repeat (2) @(posedge clock);
		resetn <= 1'b1;
		rd(8'h24, 32'h0001_0001);
		rd(8'h28, 32'h0000_0000);
		rd(8'h2C, 32'h0000_0000);
		final_report();
	end

	// Tests need about 75 cycles; allow many times that
	initial begin
		#100_000;
		mismatches++;
		final_report();
	end

endmodule

`default_nettype wire
